/* verilog/asf_pkg.sv */
// constants and types of the accelerometer sample buffer
package asf_pkg;
   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] ASF_OFF_WM = 8'h30;
   localparam logic [7:0] ASF_OFF_MODE = 8'h3e;
   localparam logic [7:0] ASF_OFF_READOUT = 8'h3f;
   localparam logic [7:0] ASF_OFF_STATUS = 8'h0a;
   localparam logic [7:0] ASF_OFF_CLEAR = 8'h0b;
   localparam logic [7:0] ASF_OFF_ENABLE = 8'h0c;
   localparam logic [7:0] ASF_OFF_LEVEL = 8'h0d;
   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int ASF_WM_LSB = 0;
   localparam int ASF_WM_W = 6;
   localparam int ASF_MODE_LSB = 6;
   localparam int ASF_DSEL_LSB = 0;
   localparam logic [5:0] ASF_WM_RST = 6'h00;
   localparam logic [1:0] ASF_MODE_RST = 2'h0;
   localparam logic [1:0] ASF_DSEL_RST = 2'h0;
   localparam int ASF_IRQ_W = 3;
   localparam int ASF_IRQ_WM = 0;
   localparam int ASF_IRQ_FULL = 1;
   localparam int ASF_IRQ_LOST = 2;
   localparam logic [ASF_IRQ_W-1:0] ASF_EN_RST = 3'h0;
   // ****************************************************************
   // frame layout
   // ****************************************************************
   localparam int ASF_DEPTH = 32;
   localparam int ASF_ACC_W = 12;
   localparam int ASF_AXIS_W = 16;
   localparam int ASF_FRAME_W = 3 * ASF_AXIS_W;
   localparam logic [2:0] ASF_LAST_XYZ = 3'h5;
   localparam logic [2:0] ASF_LAST_ONE = 3'h1;
   typedef enum logic [1:0] {
      ASF_BYPASS = 2'h0,
      ASF_FIFO = 2'h1,
      ASF_CONTINUOUS_OVERWRITE = 2'h2,
      ASF_RSVD = 2'h3
   } asf_mode_type;
   typedef enum logic [1:0] {
      ASF_SEL_XYZ = 2'h0,
      ASF_SEL_X = 2'h1,
      ASF_SEL_Y = 2'h2,
      ASF_SEL_Z = 2'h3
   } asf_dsel_type;
endpackage : asf_pkg

/* verilog/asf_irq_bit.sv */
// one sticky interrupt status bit with enable gating
`timescale 1ns/1ps
module asf_irq_bit
   import asf_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic set_in,
   input wire logic clr_in,
   input wire logic en_in,
   output logic stat_out,
   output logic pend_out
);
   logic stat_ff;
   logic nxt_stat;
   // set beats clear so an event in the clearing cycle survives
   assign nxt_stat = set_in | (stat_ff & ~clr_in);
   assign stat_out = stat_ff;
   assign pend_out = stat_ff & en_in;
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         stat_ff <= 1'b0;
      else
         stat_ff <= nxt_stat;
   end
endmodule : asf_irq_bit

/* verilog/asf_frame_mem.sv */
// frame storage: flip-flop array, one write and one read index
`timescale 1ns/1ps
module asf_frame_mem
   import asf_pkg::*;
#(
   parameter int WIDTH = ASF_FRAME_W,
   parameter int DEPTH = ASF_DEPTH,
   parameter int AW = $clog2(DEPTH)
)
(
   input wire logic sys_clk_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_idx_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic [AW-1:0] rd_idx_in,
   output logic [WIDTH-1:0] rd_data_out
);
   // no reset: contents are never read before a write fills them
   logic [WIDTH-1:0] mem_ff [DEPTH];
   assign rd_data_out = mem_ff[rd_idx_in];
   always_ff @(posedge sys_clk_in)
   begin
      if (wr_en_in)
         mem_ff[wr_idx_in] <= wr_data_in;
   end
endmodule : asf_frame_mem

/* verilog/asf_top.sv */
// accelerometer sample buffer: control, readout and registers
`timescale 1ns/1ps
module asf_top
   import asf_pkg::*;
#(
   parameter int DEPTH = ASF_DEPTH
)
(
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic burst_end_in,
   input wire logic sample_valid_in,
   input wire logic sample_new_in,
   input wire logic [ASF_ACC_W-1:0] accel_x_in,
   input wire logic [ASF_ACC_W-1:0] accel_y_in,
   input wire logic [ASF_ACC_W-1:0] accel_z_in,
   output logic [7:0] reg_rdata_out,
   output logic irq_out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [5:0] FULL_CNT = 6'(DEPTH);
   // ****************************************************************
   // state
   // ****************************************************************
   logic [5:0] count_ff;
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [2:0] byte_idx_ff;
   logic full_ff;
   logic [5:0] wm_ff;
   asf_mode_type mode_ff;
   asf_dsel_type dsel_ff;
   logic [ASF_IRQ_W-1:0] en_ff;
   logic [7:0] rdata_ff;
   logic [5:0] nxt_count;
   logic [AW-1:0] nxt_wr_ptr;
   logic [AW-1:0] nxt_rd_ptr;
   logic [2:0] nxt_byte_idx;
   logic nxt_full;
   logic [7:0] nxt_rdata;
   // ****************************************************************
   // register decode
   // ****************************************************************
   wire sel_wm = reg_addr_in == ASF_OFF_WM;
   wire sel_mode = reg_addr_in == ASF_OFF_MODE;
   wire sel_readout = reg_addr_in == ASF_OFF_READOUT;
   wire sel_status = reg_addr_in == ASF_OFF_STATUS;
   wire sel_clear = reg_addr_in == ASF_OFF_CLEAR;
   wire sel_enable = reg_addr_in == ASF_OFF_ENABLE;
   wire sel_level = reg_addr_in == ASF_OFF_LEVEL;
   wire wr_wm = reg_wr_in & sel_wm;
   wire wr_mode = reg_wr_in & sel_mode;
   wire wr_clear = reg_wr_in & sel_clear;
   wire wr_enable = reg_wr_in & sel_enable;
   wire rd_readout = reg_rd_in & sel_readout;
   // ****************************************************************
   // fill control
   // ****************************************************************
   wire three_axis = dsel_ff == ASF_SEL_XYZ;
   wire [2:0] last_idx = three_axis ? ASF_LAST_XYZ : ASF_LAST_ONE;
   wire empty = count_ff == 6'h00;
   wire byte_take = rd_readout & ~empty;
   wire frame_done = byte_take & (byte_idx_ff == last_idx);
   // a burst that stops inside a frame gives the rest of it up
   wire abandon = burst_end_in & ~empty &
                  ((byte_idx_ff != 3'h0) | byte_take);
   wire pop = frame_done | abandon;
   wire [5:0] cap = (mode_ff == ASF_BYPASS) ? 6'h01 : FULL_CNT;
   wire [5:0] count_ap = count_ff - {5'h00, pop};
   wire room = count_ap < cap;
   wire overwrite = (mode_ff == ASF_BYPASS) |
                    (mode_ff == ASF_CONTINUOUS_OVERWRITE);
   wire push = sample_valid_in & ~wr_mode;
   wire push_ok = push & (room | overwrite);
   wire drop = push & ~room & overwrite;
   wire lost = push & ~room & ~overwrite;
   wire [5:0] grow = {5'h00, push_ok & ~drop};
   // ****************************************************************
   // frame assembly, data register layout with new-data flag
   // ****************************************************************
   function automatic logic [ASF_AXIS_W-1:0] axis_img(
      input logic [ASF_ACC_W-1:0] d,
      input logic nd
   );
      axis_img = {d[11:4], d[3:0], 3'h0, nd};
   endfunction : axis_img
   wire [ASF_AXIS_W-1:0] img_x = axis_img(accel_x_in, sample_new_in);
   wire [ASF_AXIS_W-1:0] img_y = axis_img(accel_y_in, sample_new_in);
   wire [ASF_AXIS_W-1:0] img_z = axis_img(accel_z_in, sample_new_in);
   // single-axis frames sit in the X slot so readout starts at byte 0
   wire [ASF_AXIS_W-1:0] img_one = (dsel_ff == ASF_SEL_Y) ? img_y :
                                   (dsel_ff == ASF_SEL_Z) ? img_z :
                                   img_x;
   wire [ASF_FRAME_W-1:0] wr_frame = three_axis ?
      {img_z, img_y, img_x} : {32'h0000_0000, img_one};
   wire [ASF_FRAME_W-1:0] rd_frame;
   asf_frame_mem #(
      .WIDTH(ASF_FRAME_W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_mem (
      .sys_clk_in(sys_clk_in),
      .wr_en_in(push_ok),
      .wr_idx_in(wr_ptr_ff),
      .wr_data_in(wr_frame),
      .rd_idx_in(rd_ptr_ff),
      .rd_data_out(rd_frame)
   );
   // byte order X lo, X hi, Y lo, Y hi, Z lo, Z hi
   wire [7:0] rd_byte = empty ? 8'h00 :
                        rd_frame[{byte_idx_ff, 3'h0} +: 8];
   // ****************************************************************
   // next state
   // ****************************************************************
   assign nxt_count = wr_mode ? 6'h00 : 6'(count_ap + grow);
   assign nxt_wr_ptr = wr_mode ? '0 :
                       AW'(wr_ptr_ff + {{(AW-1){1'b0}}, push_ok});
   assign nxt_rd_ptr = wr_mode ? '0 :
                       AW'(rd_ptr_ff + {{(AW-1){1'b0}}, pop | drop});
   // address stays put; a non-empty readout read steps the byte index, back to 0 at frame end, on a burst end mid-frame, on a drop or on a mode write
   assign nxt_byte_idx = (wr_mode | pop | drop) ? 3'h0 :
                         byte_take ? 3'(byte_idx_ff + 3'h1) :
                         byte_idx_ff;
   assign nxt_full = ~wr_mode &
                     (full_ff | (nxt_count == FULL_CNT));
   wire wm_evt = ~wr_mode & (nxt_count == wm_ff) &
                 (count_ff != wm_ff);
   // ****************************************************************
   // interrupts
   // ****************************************************************
   wire [ASF_IRQ_W-1:0] irq_set = {lost | drop,
                                   nxt_full & ~full_ff, wm_evt};
   wire [ASF_IRQ_W-1:0] irq_clr = wr_clear ?
                                  reg_wdata_in[ASF_IRQ_W-1:0] : '0;
   logic [ASF_IRQ_W-1:0] stat;
   logic [ASF_IRQ_W-1:0] pend;
   for (genvar i = 0; i < ASF_IRQ_W; i++)
   begin : g_irq
      asf_irq_bit u_bit (
         .sys_clk_in(sys_clk_in),
         .nrst_in(nrst_in),
         .set_in(irq_set[i]),
         .clr_in(irq_clr[i]),
         .en_in(en_ff[i]),
         .stat_out(stat[i]),
         .pend_out(pend[i])
      );
   end
   assign irq_out = |pend;
   // ****************************************************************
   // read mux
   // ****************************************************************
   wire [7:0] rmux =
      sel_readout ? rd_byte :
      sel_wm ? {2'h0, wm_ff} :
      sel_mode ? {mode_ff, 4'h0, dsel_ff} :
      sel_status ? {5'h00, stat} :
      sel_enable ? {5'h00, en_ff} :
      sel_level ? {1'b0, full_ff, count_ff} :
      8'h00;
   assign nxt_rdata = reg_rd_in ? rmux : 8'h00;
   assign reg_rdata_out = rdata_ff;
   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         count_ff <= 6'h00;
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         byte_idx_ff <= 3'h0;
         full_ff <= 1'b0;
         rdata_ff <= 8'h00;
      end
      else
      begin
         count_ff <= nxt_count;
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         byte_idx_ff <= nxt_byte_idx;
         full_ff <= nxt_full;
         rdata_ff <= nxt_rdata;
      end
   end
   // reserved mode 11b is the host's to avoid; it then acts as 01b
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         wm_ff <= ASF_WM_RST;
         mode_ff <= asf_mode_type'(ASF_MODE_RST);
         dsel_ff <= asf_dsel_type'(ASF_DSEL_RST);
         en_ff <= ASF_EN_RST;
      end
      else
      begin
         if (wr_wm)
            wm_ff <= reg_wdata_in[ASF_WM_LSB +: ASF_WM_W];
         if (wr_mode)
         begin
            mode_ff <= asf_mode_type'(reg_wdata_in[ASF_MODE_LSB +: 2]);
            dsel_ff <= asf_dsel_type'(reg_wdata_in[ASF_DSEL_LSB +: 2]);
         end
         if (wr_enable)
            en_ff <= reg_wdata_in[ASF_IRQ_W-1:0];
      end
   end
   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!nrst_in);
   chk_wm_event: assert property (
      wm_evt |=> stat[ASF_IRQ_WM] && count_ff == $past(wm_ff))
      else $error("watermark event not flagged");
   chk_mode_clear: assert property (
      wr_mode |=> count_ff == 6'h00 && !full_ff && byte_idx_ff == 3'h0)
      else $error("mode write did not empty buffer");
   chk_bypass_depth: assert property (
      mode_ff == ASF_BYPASS |-> count_ff <= 6'h01)
      else $error("bypass mode holds more than one frame");
   chk_fifo_stop: assert property (
      mode_ff == ASF_FIFO && count_ff == FULL_CNT && push && !pop
      |=> $stable(wr_ptr_ff) && count_ff == FULL_CNT
          && stat[ASF_IRQ_LOST])
      else $error("fifo mode accepted frame when full");
   chk_overwrite_drop: assert property (
      mode_ff == ASF_CONTINUOUS_OVERWRITE && count_ff == FULL_CNT
      && push && !pop
      |=> count_ff == FULL_CNT
          && rd_ptr_ff == AW'($past(rd_ptr_ff) + 1'b1))
      else $error("overwrite mode did not drop oldest frame");
   chk_axis_store: assert property (
      push_ok && dsel_ff == ASF_SEL_Z
      |-> wr_frame[15:4] == {accel_z_in[11:4], accel_z_in[3:0]})
      else $error("wrong axis stored");
   chk_low_layout: assert property (
      byte_take && !byte_idx_ff[0] |=> reg_rdata_out[3:1] == 3'h0)
      else $error("low byte layout broken");
   chk_burst_step: assert property (
      byte_take && !pop && !drop
      |=> byte_idx_ff == 3'($past(byte_idx_ff) + 3'h1))
      else $error("burst read did not advance");
   chk_partial_drop: assert property (
      burst_end_in && byte_idx_ff != 3'h0 && !empty && !wr_mode
      && !drop
      |=> byte_idx_ff == 3'h0
          && rd_ptr_ff == AW'($past(rd_ptr_ff) + 1'b1))
      else $error("partial frame not discarded");
   chk_xyz_len: assert property (
      three_axis && byte_take |-> byte_idx_ff <= ASF_LAST_XYZ)
      else $error("three-axis frame longer than six bytes");
   chk_single_len: assert property (
      !three_axis && byte_take && byte_idx_ff == ASF_LAST_ONE
      && !wr_mode |=> byte_idx_ff == 3'h0)
      else $error("single-axis frame not two bytes");
   chk_full_hold: assert property (
      full_ff && !wr_mode |=> full_ff)
      else $error("full flag dropped without clear");
   chk_full_at_depth: assert property (
      count_ff == FULL_CNT |-> full_ff)
      else $error("full flag missing at depth");
   chk_fill_bound: assert property (
      count_ff <= FULL_CNT)
      else $error("buffer holds more than its depth");
   chk_lost_flag: assert property (
      lost |=> stat[ASF_IRQ_LOST])
      else $error("refused frame not flagged");
   chk_wm_equal: assert property (
      $rose(stat[ASF_IRQ_WM]) |-> count_ff == $past(wm_ff))
      else $error("watermark flag at wrong fill");
   chk_frame_pop: assert property (
      frame_done && !push
      |=> count_ff == 6'($past(count_ff) - 6'h01))
      else $error("read frame not removed");
   chk_mode_held: assert property (
      !wr_mode |=> $stable(mode_ff) && $stable(dsel_ff))
      else $error("mode changed without write");
   // read data is zero outside its one cycle so stale bytes never leak
   chk_read_idle: assert property (
      !reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data outside read cycle");
   chk_empty_read: assert property (
      rd_readout && empty
      |=> reg_rdata_out == 8'h00 && $stable(byte_idx_ff))
      else $error("readout on empty buffer stepped");
   // ****************************************************************
   // cover points
   // ****************************************************************
   cov_overwrite_wrap: cover property (
      mode_ff == ASF_CONTINUOUS_OVERWRITE && drop);
   cov_partial: cover property (abandon && !frame_done);
   cov_wm_irq: cover property (wm_evt ##1 irq_out);
   cov_fifo_full: cover property (mode_ff == ASF_FIFO && lost);
   cov_bypass_replace: cover property (
      mode_ff == ASF_BYPASS && drop);
endmodule : asf_top

/* bench/asf_host_model.sv */
// host model driving the register port of the sample buffer
`timescale 1ns/1ps
module asf_host_model
   import asf_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic [7:0] reg_rdata_in,
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic burst_end_out
);
   // ********
   // bus cycles
   // ********
   initial
   begin
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      burst_end_out = 1'b0;
   end
   // a reserved mode request is turned into stop-when-full
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= (a == ASF_OFF_MODE && d[7:6] == 2'h3) ?
         {2'h1, d[5:0]} : d;
      reg_wr_out <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_out <= 1'b0;
      // data is meaningless once the strobe drops
      reg_wdata_out <= ~d;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_out <= 1'b0;
      #1 d = reg_rdata_in;
   endtask : rd_reg
   task automatic end_burst;
      @(posedge sys_clk_in);
      burst_end_out <= 1'b1;
      @(posedge sys_clk_in);
      burst_end_out <= 1'b0;
   endtask : end_burst
endmodule : asf_host_model

/* bench/tb_asf_top.sv */
// self-checking bench of the accelerometer sample buffer
`timescale 1ns/1ps
module tb_asf_top
   import asf_pkg::*;
;
   logic sys_clk_in, nrst_in, reg_wr_in, reg_rd_in, burst_end_in;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic sample_valid_in, sample_new_in, irq_out;
   logic [ASF_ACC_W-1:0] accel_x_in, accel_y_in, accel_z_in;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   asf_top #(.DEPTH(ASF_DEPTH)) asf_top_i (.sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .burst_end_in(burst_end_in),
      .sample_valid_in(sample_valid_in), .sample_new_in(sample_new_in),
      .accel_x_in(accel_x_in), .accel_y_in(accel_y_in),
      .accel_z_in(accel_z_in), .reg_rdata_out(reg_rdata_out),
      .irq_out(irq_out));
   asf_host_model asf_host_model_i (.sys_clk_in(sys_clk_in),
      .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in),
      .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in),
      .reg_rd_out(reg_rd_in), .burst_end_out(burst_end_in));
   // ********
   // helpers
   // ********
   initial
   begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   function automatic logic [11:0] axv(input logic [11:0] v, input int k);
      return (k == 0) ? v : v ^ ((k == 1) ? 12'h0f0 : 12'hf00);
   endfunction : axv
   // low byte carries the new-data flag in bit 0
   function automatic logic [7:0] eb(input logic [11:0] v, input int k,
      input int h);
      logic [11:0] a;
      a = axv(v, k);
      return (h == 1) ? a[11:4] : {a[3:0], 3'h0, v[0]};
   endfunction : eb
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e,
      input string nm);
      logic [7:0] g;
      asf_host_model_i.rd_reg(a, g);
      chk(nm, e, g);
   endtask : rchk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      asf_host_model_i.wr_reg(a, d);
   endtask : wr
   task automatic rframe(input logic [11:0] v, input int k0, input int nk);
      for (int k = k0; k < k0 + nk; k++)
         for (int h = 0; h < 2; h++)
            rchk(ASF_OFF_READOUT, eb(v, k, h), "readout");
   endtask : rframe
   task automatic setmode(input logic [1:0] m, input logic [1:0] s);
      wr(ASF_OFF_MODE, {m, 4'h0, s});
      wr(ASF_OFF_CLEAR, 8'h07);
   endtask : setmode
   task automatic push(input logic [11:0] v);
      @(posedge sys_clk_in);
      sample_valid_in <= 1'b1;
      sample_new_in <= v[0];
      accel_x_in <= axv(v, 0);
      accel_y_in <= axv(v, 1);
      accel_z_in <= axv(v, 2);
      @(posedge sys_clk_in);
      sample_valid_in <= 1'b0;
   endtask : push
   always @(posedge sys_clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         wrap_up();
      end
   end
   // ********
   // tests
   // ********
   initial
   begin
      nrst_in = 1'b0;
      sample_valid_in = 1'b0;
      sample_new_in = 1'b0;
      accel_x_in = 12'h000;
      accel_y_in = 12'h000;
      accel_z_in = 12'h000;
      repeat (10) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      rchk(ASF_OFF_MODE, 8'h00, "mode reset");
      rchk(ASF_OFF_WM, 8'h00, "watermark reset");
      rchk(ASF_OFF_LEVEL, 8'h00, "level reset");
      rchk(8'h55, 8'h00, "unmapped");
      rchk(ASF_OFF_ENABLE, 8'h00, "enable reset");
      rchk(ASF_OFF_STATUS, 8'h00, "status reset");
      chk("irq", 8'h00, {7'h0, irq_out});
      $display("test reset done");
      setmode(2'h1, 2'h0);
      push(12'h5a3);
      rchk(ASF_OFF_LEVEL, 8'h01, "level");
      rframe(12'h5a3, 0, 3);
      rchk(ASF_OFF_LEVEL, 8'h00, "level");
      $display("test three axes done");
      for (int s = 1; s < 4; s++)
      begin
         setmode(2'h1, s[1:0]);
         push(12'h3c1);
         push(12'ha52);
         rframe(12'h3c1, s - 1, 1);
         rframe(12'ha52, s - 1, 1);
      end
      $display("test single axis done");
      setmode(2'h1, 2'h0);
      push(12'h111);
      push(12'h222);
      rchk(ASF_OFF_READOUT, eb(12'h111, 0, 0), "readout");
      asf_host_model_i.end_burst();
      rchk(ASF_OFF_LEVEL, 8'h01, "level");
      rframe(12'h222, 0, 3);
      $display("test partial frame done");
      setmode(2'h1, 2'h0);
      for (int i = 0; i < 33; i++)
         push(12'h400 + i[11:0]);
      rchk(ASF_OFF_LEVEL, 8'h60, "level");
      rchk(ASF_OFF_STATUS, 8'h06, "status");
      rframe(12'h400, 0, 1);
      asf_host_model_i.end_burst();
      rchk(ASF_OFF_LEVEL, 8'h5f, "level");
      wr(ASF_OFF_MODE, 8'h40);
      rchk(ASF_OFF_LEVEL, 8'h00, "level");
      $display("test stop when full done");
      setmode(2'h2, 2'h0);
      for (int i = 0; i < 33; i++)
         push(12'h600 + i[11:0]);
      rchk(ASF_OFF_LEVEL, 8'h60, "level");
      rframe(12'h601, 0, 3);
      $display("test overwrite done");
      setmode(2'h0, 2'h0);
      push(12'h700);
      push(12'h701);
      rchk(ASF_OFF_LEVEL, 8'h01, "level");
      rframe(12'h701, 0, 3);
      $display("test single frame done");
      wr(ASF_OFF_WM, 8'h03);
      setmode(2'h1, 2'h0);
      wr(ASF_OFF_ENABLE, 8'h01);
      rchk(ASF_OFF_ENABLE, 8'h01, "enable");
      push(12'h010);
      push(12'h020);
      repeat (3) @(negedge sys_clk_in);
      chk("irq", 8'h00, {7'h0, irq_out});
      push(12'h030);
      repeat (3) @(negedge sys_clk_in);
      chk("irq", 8'h01, {7'h0, irq_out});
      rchk(ASF_OFF_STATUS, 8'h01, "status");
      wr(ASF_OFF_ENABLE, 8'h00);
      // mask lands at the strobe edge; look half a cycle later
      @(negedge sys_clk_in);
      chk("irq masked", 8'h00, {7'h0, irq_out});
      wr(ASF_OFF_ENABLE, 8'h01);
      wr(ASF_OFF_CLEAR, 8'h01);
      @(negedge sys_clk_in);
      chk("irq cleared", 8'h00, {7'h0, irq_out});
      rchk(ASF_OFF_STATUS, 8'h00, "status");
      $display("test watermark done");
      wrap_up();
   end
endmodule : tb_asf_top
